// ---- rtl/mir_id_cfg.svh ----
// Constants of the module identification register bank.
// Assumes the including file reaches it by bare name.
`ifndef MIR_ID_CFG_SVH
`define MIR_ID_CFG_SVH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define MIR_IDX_FORM       16'h8000
`define MIR_IDX_EXT        16'h8001
`define MIR_IDX_CONN       16'h8002
`define MIR_IDX_ETH        16'h8003
`define MIR_IDX_FC         16'h8004
`define MIR_IDX_COPPER     16'h8005
`define MIR_IDX_SONET      16'h8006
`define MIR_IDX_OTN        16'h8007
`define MIR_IDX_RATES      16'h8008
`define MIR_IDX_LANES      16'h8009
`define MIR_IDX_MEDIA      16'h800A
`define MIR_IDX_NET_RATE   16'h800B
`define MIR_IDX_CTRL       16'h80F0
`define MIR_IDX_STAT       16'h80F1

// ------------------------------------------------------------
// Field values
// ------------------------------------------------------------
`define MIR_APP_UNDEF      8'h00
`define MIR_LANES_MAX      16
`define MIR_LANES_ENC_MAX  4'h0
`define MIR_RESV_ZERO      1'h0
`define MIR_CTRL_RESET     1'h0
`define MIR_CNT_RESET      16'h0000
`define MIR_CNT_STEP       16'h0001
`define MIR_BYTE_ZERO      8'h00
`define MIR_WORD_ZERO      32'h0000_0000
`define MIR_ALIGN_OK       2'h0

`endif

// ---- rtl/mir_id_pkg.sv ----
// Types shared by the identification register bank.
// Assumes mir_id_cfg.svh supplies the numeric constants.
package mir_id_pkg;

    typedef logic [7:0]  mir_byte_t;
    typedef logic [15:0] mir_idx_t;
    typedef logic [3:0]  mir_lane_enc_t;

endpackage : mir_id_pkg

// ---- rtl/mir_id_regs.sv ----
// APB slave serving the fixed identification bytes of the module.
// Assumes an APB master on sys_clk; contents fixed by parameters.
`timescale 1ns/10ps
`include "mir_id_cfg.svh"

module mir_id_regs #(
    parameter int                 AW              = 18,
    // Arbitrary neutral value, not a real form-factor code
    parameter mir_id_pkg::mir_byte_t FORM_CODE    = 8'h5A,
    parameter logic [1:0]         POWER_CLASS     = 2'h0,
    parameter logic [1:0]         LANE_RATIO      = 2'h0,
    parameter logic [2:0]         GRID_SPACING    = 3'h0,
    parameter mir_id_pkg::mir_byte_t CONN_CODE    = 8'h01,
    parameter bit                 ETH_SUPPORTED   = 1'b1,
    parameter mir_id_pkg::mir_byte_t ETH_CODE     = 8'h01,
    parameter bit                 FC_SUPPORTED    = 1'b0,
    parameter mir_id_pkg::mir_byte_t FC_CODE      = 8'h01,
    parameter mir_id_pkg::mir_byte_t COPPER_CODE  = 8'h00,
    parameter bit                 SONET_SUPPORTED = 1'b0,
    parameter mir_id_pkg::mir_byte_t SONET_CODE   = 8'h01,
    parameter bit                 OTN_SUPPORTED   = 1'b0,
    parameter mir_id_pkg::mir_byte_t OTN_CODE     = 8'h01,
    parameter mir_id_pkg::mir_byte_t EXTRA_RATES  = 8'h00,
    parameter int                 NET_LANES       = 4,
    parameter int                 HOST_LANES      = 10,
    parameter logic [1:0]         MEDIA_TYPE      = 2'h0,
    parameter bit                 BIDIR           = 1'b0,
    parameter mir_id_pkg::mir_byte_t NET_RATE     = 8'h7D
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [AW-1:0]     paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr
);
    import mir_id_pkg::*;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    // Sixteen lanes does not fit four bits, so it wraps to zero
    function automatic mir_lane_enc_t lane_enc(input int n);
        mir_lane_enc_t r;
        r = 4'(n);
        if (n == `MIR_LANES_MAX)
            r = `MIR_LANES_ENC_MAX;
        return r;
    endfunction : lane_enc

    function automatic mir_byte_t app_sel(input bit sup, input mir_byte_t code);
        return sup ? code : `MIR_APP_UNDEF;
    endfunction : app_sel

    // Lanes are counted, so indices 0..n-1 are implied with no gap
    localparam mir_lane_enc_t NET_ENC  = lane_enc(NET_LANES);
    localparam mir_lane_enc_t HOST_ENC = lane_enc(HOST_LANES);

    localparam mir_byte_t EXT_BYTE   = {POWER_CLASS, LANE_RATIO,
                                        GRID_SPACING, `MIR_RESV_ZERO};
    localparam mir_byte_t LANE_BYTE  = {NET_ENC, HOST_ENC};
    localparam mir_byte_t MEDIA_BYTE = {MEDIA_TYPE, BIDIR,
                                        5'h00};

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic            pready_reg;
    logic            pready_next;
    logic            pslverr_reg;
    logic            pslverr_next;
    logic [31:0]     prdata_reg;
    logic [31:0]     prdata_next;
    logic            wr_err_en_reg;
    logic            wr_err_en_next;
    logic [15:0]     rd_cnt_reg;
    logic [15:0]     rd_cnt_next;

    wire mir_idx_t   idx      = mir_idx_t'(paddr[AW-1:2]);
    wire             aligned  = (paddr[1:0] == `MIR_ALIGN_OK);
    wire             setup    = psel & ~penable & ~pready_reg;
    wire             done     = psel & penable & pready_reg;
    wire             id_hit   = aligned && (idx >= `MIR_IDX_FORM)
                                        && (idx <= `MIR_IDX_NET_RATE);
    wire             ctrl_hit = aligned && (idx == `MIR_IDX_CTRL);
    wire             stat_hit = aligned && (idx == `MIR_IDX_STAT);
    wire             mapped   = id_hit | ctrl_hit | stat_hit;

    // ------------------------------------------------------------
    // Identification contents, fixed regardless of history
    // ------------------------------------------------------------
    mir_byte_t id_byte;
    always_comb
    begin
        case (idx)
            `MIR_IDX_FORM:     id_byte = FORM_CODE;
            `MIR_IDX_EXT:      id_byte = EXT_BYTE;
            `MIR_IDX_CONN:     id_byte = CONN_CODE;
            `MIR_IDX_ETH:      id_byte = app_sel(ETH_SUPPORTED, ETH_CODE);
            `MIR_IDX_FC:       id_byte = app_sel(FC_SUPPORTED, FC_CODE);
            `MIR_IDX_COPPER:   id_byte = COPPER_CODE;
            `MIR_IDX_SONET:    id_byte = app_sel(SONET_SUPPORTED, SONET_CODE);
            `MIR_IDX_OTN:      id_byte = app_sel(OTN_SUPPORTED, OTN_CODE);
            `MIR_IDX_RATES:    id_byte = EXTRA_RATES;
            `MIR_IDX_LANES:    id_byte = LANE_BYTE;
            `MIR_IDX_MEDIA:    id_byte = MEDIA_BYTE;
            `MIR_IDX_NET_RATE: id_byte = NET_RATE;
            default:           id_byte = `MIR_BYTE_ZERO;
        endcase
    end

    // ------------------------------------------------------------
    // Next-state terms
    // ------------------------------------------------------------
    // Data is prepared in the setup cycle so the access needs no wait
    assign pready_next  = setup;
    assign prdata_next  = !setup   ? prdata_reg :
                          pwrite   ? `MIR_WORD_ZERO :
                          id_hit   ? {24'h000000, id_byte} :
                          ctrl_hit ? {31'h00000000, wr_err_en_reg} :
                          stat_hit ? {16'h0000, rd_cnt_reg} :
                                     `MIR_WORD_ZERO;
    // Writes to identification bytes never store; error only if asked
    assign pslverr_next = setup & (~mapped | (pwrite & id_hit & wr_err_en_reg));
    assign wr_err_en_next = (done & pwrite & ctrl_hit & pstrb[0]) ? pwdata[0]
                                                                  : wr_err_en_reg;
    assign rd_cnt_next  = (done & ~pwrite & id_hit) ? rd_cnt_reg + `MIR_CNT_STEP
                                                    : rd_cnt_reg;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready_reg    <= 1'b0;
            pslverr_reg   <= 1'b0;
            prdata_reg    <= `MIR_WORD_ZERO;
            wr_err_en_reg <= `MIR_CTRL_RESET;
            rd_cnt_reg    <= `MIR_CNT_RESET;
        end
        else
        begin
            pready_reg    <= pready_next;
            pslverr_reg   <= pslverr_next;
            prdata_reg    <= prdata_next;
            wr_err_en_reg <= wr_err_en_next;
            rd_cnt_reg    <= rd_cnt_next;
        end
    end

    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata  = prdata_reg;

endmodule : mir_id_regs

// ---- verif/mir_id_asserts.sv ----
// Checker of the identification bank's APB answers.
// Assumes it is bound onto mir_id_regs and sees its ports only.
`timescale 1ns/10ps
module mir_id_asserts #(
    parameter int         AW         = 18,
    parameter logic [7:0] FORM_CODE  = 8'h5A,
    parameter int         NET_LANES  = 4,
    parameter int         HOST_LANES = 10,
    parameter logic [1:0] MEDIA_TYPE = 2'h0,
    parameter bit         BIDIR      = 1'b0
) (
    // Clock, reset and APB
    input wire logic          sys_clk, rst_n, psel, penable, pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0]   prdata,
    input wire logic          pready, pslverr
);
    wire rd_ok = pready && !pwrite;
    wire is_id = paddr[1:0] == 2'h0 && paddr[AW-1:2] >= 16'h8000 && paddr[AW-1:2] <= 16'h800B;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_zero_wait: assert property (psel && !penable |=> pready)
        else $error("setup not answered in next cycle");
    a_one_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_bad_addr: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
        else $error("misaligned access not refused");
    a_id_read: assert property (rd_ok && is_id |-> !pslverr && prdata[31:8] == 24'h0)
        else $error("identification read refused or padded wrongly");
    a_form_code: assert property (rd_ok && paddr == 18'h20000 |-> prdata[7:0] == FORM_CODE)
        else $error("form code wrong");
    a_net_lanes: assert property (rd_ok && paddr == 18'h20024 |-> prdata[7:4] == 4'(NET_LANES % 16))
        else $error("network lane count wrong");
    a_host_lanes: assert property (rd_ok && paddr == 18'h20024 |-> prdata[3:0] == 4'(HOST_LANES % 16))
        else $error("host lane count wrong");
    a_media_type: assert property (rd_ok && paddr == 18'h20028 |-> prdata[7:6] == MEDIA_TYPE)
        else $error("medium type wrong");
    a_direction: assert property (rd_ok && paddr == 18'h20028 |-> prdata[5] == BIDIR)
        else $error("directionality wrong");
endmodule : mir_id_asserts

bind mir_id_regs mir_id_asserts #(.AW(AW), .FORM_CODE(FORM_CODE), .NET_LANES(NET_LANES),
    .HOST_LANES(HOST_LANES), .MEDIA_TYPE(MEDIA_TYPE), .BIDIR(BIDIR)) u_chk (.sys_clk(sys_clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ---- verif/mir_host_model.sv ----
// Host controller model: APB master with one transfer task.
// Assumes the bench calls xfer by hierarchy, one call at a time.
`timescale 1ns/10ps
module mir_host_model (
    // APB master side
    input  wire logic        sys_clk,
    output logic             psel, penable, pwrite,
    output logic [17:0]      paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready, pslverr
);
    initial
    begin
        {psel, penable, pwrite} = 3'h0;
        paddr = 18'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
    end
    // One transfer: setup, then access until pready; returns prdata and pslverr
    task automatic xfer(input logic w, input logic [17:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        pstrb <= {4{w}};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
        // Released pwrite, paddr and pwdata flip so stale values cannot pass
        pwrite <= ~w;
        paddr <= ~a;
        pwdata <= ~wd;
    endtask : xfer
endmodule : mir_host_model

// ---- verif/module_identification_rom_test.sv ----
// Bench of the identification bank: reads, ignored writes, refusals, reset.
// Assumes mir_host_model drives APB and the checker is bound in.
`timescale 1ns/10ps
module module_identification_rom_test;
    logic        sys_clk = 1'b0, rst_n = 1'b0, psel, penable, pwrite, pready, pslverr, err;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [7:0]  exp_id [12] = '{8'h5A, 8'hDA, 8'h07, 8'h01, 8'h21, 8'h00,
                                 8'h00, 8'h12, 8'h00, 8'h0A, 8'hA0, 8'h7D};
    int          fails = 0, checks_done = 0;
    always #20 sys_clk = ~sys_clk;
    mir_host_model u_host (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    // Sixteen network lanes to hit the zero encoding
    mir_id_regs #(.POWER_CLASS(2'h3), .LANE_RATIO(2'h1), .GRID_SPACING(3'h5), .CONN_CODE(8'h07),
        .FC_SUPPORTED(1'b1), .FC_CODE(8'h21), .OTN_SUPPORTED(1'b1), .OTN_CODE(8'h12),
        .NET_LANES(16), .MEDIA_TYPE(2'h2), .BIDIR(1'b1)) u_dut (.sys_clk(sys_clk),
        .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    initial
    begin
        #400000;
        fails++;
        finish_test();
    end
    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 12; i++)
        begin
            u_host.xfer(1'b0, {16'h8000 + 16'(i), 2'h0}, 32'h0, rd, err);
            chk(rd, {24'h0, exp_id[i]});
            u_host.xfer(1'b1, {16'h8000 + 16'(i), 2'h0}, 32'hFFFF_FFFF, rd, err);
            chk(32'(err), 32'h0);
            u_host.xfer(1'b0, {16'h8000 + 16'(i), 2'h0}, 32'h0, rd, err);
            chk(rd, {24'h0, exp_id[i]});
        end
        u_host.xfer(1'b0, 18'h203C4, 32'h0, rd, err);
        chk(rd, 32'h18);
        u_host.xfer(1'b1, 18'h203C0, 32'h1, rd, err);
        u_host.xfer(1'b1, 18'h20000, 32'h0, rd, err);
        chk(32'(err), 32'h1);
        u_host.xfer(1'b0, 18'h20000, 32'h0, rd, err);
        chk(rd, 32'h5A);
        u_host.xfer(1'b0, 18'h20400, 32'h0, rd, err);
        chk({rd[30:0], err}, 32'h1);
        u_host.xfer(1'b0, 18'h20001, 32'h0, rd, err);
        chk(32'(err), 32'h1);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        u_host.xfer(1'b0, 18'h203C0, 32'h0, rd, err);
        chk(rd, 32'h0);
        finish_test();
    end
endmodule : module_identification_rom_test
